// file: audio_conv_model.sv
// Behavioural audio converter and remote bypass switch facing the delay engine
`timescale 1ns/1ps
module audio_conv_model (
   input  wire logic               clk_sys,         // System clock
   input  wire logic               resetn,          // Async reset, low
   input  wire logic               out_valid,       // Engine output strobe
   input  wire logic signed [15:0] next_l,          // Left sample to send next
   input  wire logic signed [15:0] next_r,          // Right sample to send next
   input  wire logic               remote_on,       // Remote switch closed
   output logic signed [15:0]      left_in,         // Left converter sample
   output logic signed [15:0]      right_in,        // Right converter sample
   output logic                    bypass_remote_n  // Remote pin, pulled up when open
);
   // New samples land just after a strobe, so they stand still across the next tick
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         left_in  <= 16'sh0000;
         right_in <= 16'sh0000;
      end else if (out_valid) begin
         left_in  <= next_l;
         right_in <= next_r;
      end
   end
   // An open switch leaves the pin at its pull-up level
   assign bypass_remote_n = ~remote_on;
endmodule

// file: delay_pkg.sv
// Shared constants, register map and carrier types for the stereo tap delay engine
package delay_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_HZ     = 20_000_000;            // System clock rate
   localparam int unsigned SAMPLE_HZ  = 44_100;                // Audio sample rate
   localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;    // Clocks per sample
   localparam int unsigned DIV_W      = 9;
   localparam logic [8:0]  DIV_LAST   = 9'(SAMPLE_DIV - 1);

   // ***************************************************************
   // Datapath sizes
   // ***************************************************************
   localparam int unsigned MEM_DEPTH = 16384;                  // 16K sample words
   localparam int unsigned ADDR_W    = 14;
   localparam int unsigned IN_W      = 16;
   localparam int unsigned WORD_W    = 17;                     // Room for the L+R sum
   localparam int unsigned GAIN_W    = 8;                      // Signed, unity = 0x40
   localparam int unsigned ACC_W     = 28;
   localparam int unsigned OUT_SHIFT = 7;                      // Gain fraction plus sum halving
   localparam logic [3:0]  TAP_SPLIT = 4'h6;                   // Taps 0..5 left, 6..11 right
   localparam logic [3:0]  TAP_LAST  = 4'hB;
   localparam logic [7:0]  GAIN_UNITY    = 8'h40;
   localparam logic [7:0]  GAIN_MIX_STEP = 8'h04;
   localparam logic [7:0]  GAIN_TAP      = 8'h0A;
   localparam logic [16:0] DELAY_MAX     = 17'h03FFF;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [11:0] REG_CTRL        = 12'h000;
   localparam logic [11:0] REG_STATUS      = 12'h004;
   localparam int unsigned CTRL_W          = 13;
   localparam logic [12:0] CTRL_RESET      = 13'h0000;
   localparam int unsigned STAT_WPTR_LSB   = 0;
   localparam int unsigned STAT_BYPASS_BIT = 16;
   localparam int unsigned STAT_BUSY_BIT   = 17;

   typedef enum logic [2:0] {
      MODE_MULTITAP = 3'h0,
      MODE_COMB     = 3'h1,
      MODE_ROOM     = 3'h2,
      MODE_CLUSTER  = 3'h3,
      MODE_PAN      = 3'h4,
      MODE_LINE     = 3'h5,
      MODE_REPEAT   = 3'h6,
      MODE_SCALE    = 3'h7
   } mode_e;

   // Per-mode delay step in samples; at the widest p1 the farthest repeat tap reaches about 360 ms
   localparam logic [7:0] DELAY_STEP [8] = '{8'h02, 8'h01, 8'hA5, 8'h90,
                                             8'h01, 8'h09, 8'hA5, 8'h06};

   typedef struct packed {
      logic [3:0] p2;          // Gain set selector; sign comes from mode and tap place
      logic [3:0] p1;          // Delay placement set selector
      mode_e      mode;        // Mode selector
      logic       bypass_btn;  // Front-panel bypass
      logic       mono;        // Mono input setting
   } ctrl_s;

   typedef struct packed {
      logic [ADDR_W-1:0]        delay;
      logic signed [GAIN_W-1:0] gain;
   } tap_cfg_s;

endpackage

// file: stereo_tap_delay.sv
// Twelve-tap stereo delay engine with APB control and status
//
// Contract
// RL1: Memory takes L+R in stereo input setting, left only in mono.
// RL2: 16K-word memory at 44.1 kHz allows tap delays near 372 ms.
// RL3: Each sample read twelve distinct taps; six per output channel.
// RL4: Each tap has table delay, sign and gain; gain applied before summing.
// RL5: Mode chooses which tables both parameter selectors index.
// RL6: Parameter 1 picks one of sixteen delay sets; gains untouched.
// RL7: Parameter 2 picks one of sixteen gain and sign sets; delays untouched. Here p2 sets gain only; sign comes from mode.
// RL8: Some modes put one zero-delay dry tap per channel; p2 sets mix.
// RL9: Other modes let p2 switch taps on and off.
// RL10: Eight modes, from short comb filters to repeats near 360 ms.
// RL11: Bypass in stereo routes left to left and right to right.
// RL12: Bypass is the OR of panel button and remote input.
// RL13: Tap address is write pointer minus delay, wrapping; pointer advances per sample.
`timescale 1ns/1ps
module stereo_tap_delay (
   input  wire logic                 clk_sys,          // 20 MHz system clock
   input  wire logic                 resetn,           // Async reset, active low
   input  wire logic                 psel,             // APB select
   input  wire logic                 penable,          // APB enable
   input  wire logic                 pwrite,           // APB direction
   input  wire logic [11:0]          paddr,            // APB byte address
   input  wire logic [31:0]          pwdata,           // APB write data
   output logic      [31:0]          prdata,           // APB read data
   output logic                      pready,           // APB ready
   output logic                      pslverr,          // APB error
   input  wire logic signed [15:0]   left_in,          // Left input sample
   input  wire logic signed [15:0]   right_in,         // Right input sample
   input  wire logic                 bypass_remote_n,  // Remote bypass pin, low = on
   output logic signed [15:0]        left_out,         // Left output sample
   output logic signed [15:0]        right_out,        // Right output sample
   output logic                      out_valid         // New output pair, one cycle
);

   // ***************************************************************
   // Types and declarations
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_WRITE = 3'h1,
      ST_TAP   = 3'h2,
      ST_LAST  = 3'h3,
      ST_OUT   = 3'h4
   } seq_e;

   localparam int unsigned AW = delay_pkg::ADDR_W;
   localparam int unsigned WW = delay_pkg::WORD_W;

   seq_e                          state_ff;
   seq_e                          nxt_state;
   delay_pkg::ctrl_s              ctrl_ff;
   delay_pkg::tap_cfg_s           cfg;
   logic [delay_pkg::DIV_W-1:0]   div_ff;
   logic                          tick_ff;
   logic signed [15:0]            in_l_ff;
   logic signed [15:0]            in_r_ff;
   logic [AW-1:0]                 wptr_ff;
   logic [3:0]                    tap_idx_ff;
   logic signed [WW-1:0]          mem [delay_pkg::MEM_DEPTH];
   logic signed [WW-1:0]          rdata_ff;
   logic                          rd_valid_ff;
   logic                          rd_right_ff;
   logic signed [7:0]             rd_gain_ff;
   logic                          remote_s1_ff;
   logic                          remote_s2_ff;
   logic                          bypass_ff;
   logic [31:0]                   prdata_ff;
   logic                          pready_ff;
   logic                          pslverr_ff;
   logic signed [15:0]            left_out_ff;
   logic signed [15:0]            right_out_ff;
   logic                          out_valid_ff;
   logic signed [15:0]            left_sum;
   logic signed [15:0]            right_sum;

   // ***************************************************************
   // APB slave
   // ***************************************************************

   // Decode; the answer comes one cycle into the access phase
   wire logic        apb_start = psel && penable && !pready_ff;
   wire logic        apb_done  = psel && penable && pready_ff;
   wire logic        hit_ctrl  = (paddr == delay_pkg::REG_CTRL);
   wire logic        hit_stat  = (paddr == delay_pkg::REG_STATUS);
   wire logic        busy      = (state_ff != ST_IDLE);
   wire logic [31:0] ctrl_word = 32'(ctrl_ff);
   wire logic [31:0] stat_word = (32'(wptr_ff) << delay_pkg::STAT_WPTR_LSB) |
                                 (32'(bypass_ff) << delay_pkg::STAT_BYPASS_BIT) |
                                 (32'(busy) << delay_pkg::STAT_BUSY_BIT);
   wire logic [31:0] rd_mux    = hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h00000000;
   wire logic        bad_addr  = !(hit_ctrl || (hit_stat && !pwrite));
   wire logic        ctrl_wr   = apb_done && pwrite && hit_ctrl;

   // Answer registers, so the bus outputs come straight off flip-flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= apb_start;
         pslverr_ff <= apb_start && bad_addr;
         prdata_ff  <= (apb_start && !pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // Panel settings; a change mid-sample may glitch the audio, as on any delay unit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= delay_pkg::ctrl_s'(delay_pkg::CTRL_RESET);
      end else if (ctrl_wr) begin
         ctrl_ff <= delay_pkg::ctrl_s'(pwdata[delay_pkg::CTRL_W-1:0]);
      end
   end

   // ***************************************************************
   // Bypass request
   // ***************************************************************

   // Remote pin is asynchronous: two flops before anything reads it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         remote_s1_ff <= 1'b1;
         remote_s2_ff <= 1'b1;
      end else begin
         remote_s1_ff <= bypass_remote_n;
         remote_s2_ff <= remote_s1_ff;
      end
   end

   // Either source alone turns bypass on
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bypass_ff <= 1'b0;
      end else begin
         bypass_ff <= ctrl_ff.bypass_btn || !remote_s2_ff;   // [RL12]
      end
   end

   // ***************************************************************
   // Sample clock and input capture
   // ***************************************************************

   // Divider gives one tick per audio sample
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= (div_ff == delay_pkg::DIV_LAST) ? '0 : div_ff + 9'h001;   // [RL2]
         tick_ff <= (div_ff == delay_pkg::DIV_LAST);
      end
   end

   // Converter runs on this clock, so its samples need no synchroniser
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         in_l_ff <= '0;
         in_r_ff <= '0;
      end else if (tick_ff) begin
         in_l_ff <= left_in;
         in_r_ff <= right_in;
      end
   end

   // Mono doubles the left word so both settings land at the same level
   wire logic signed [WW-1:0] in_word = ctrl_ff.mono ? {in_l_ff, 1'b0}
                                                     : WW'(in_l_ff) + WW'(in_r_ff);   // [RL1]

   // ***************************************************************
   // Sequencer
   // ***************************************************************

   // One write, twelve reads, one drain cycle, one output cycle per sample
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (tick_ff) begin
               nxt_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            nxt_state = ST_TAP;
         end
         ST_TAP: begin
            if (tap_idx_ff == delay_pkg::TAP_LAST) begin   // [RL3]
               nxt_state = ST_LAST;
            end
         end
         ST_LAST: begin
            nxt_state = ST_OUT;
         end
         ST_OUT: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_ff   <= ST_IDLE;
         tap_idx_ff <= '0;
         wptr_ff    <= '0;
      end else begin
         state_ff   <= nxt_state;
         tap_idx_ff <= (state_ff == ST_TAP) ? tap_idx_ff + 4'h1 : '0;
         if (state_ff == ST_OUT) begin
            wptr_ff <= wptr_ff + 14'h0001;   // [RL13]
         end
      end
   end

   // ***************************************************************
   // Delay memory and tap reads
   // ***************************************************************

   tap_preset u_preset (
      .ctrl    (ctrl_ff),
      .tap_idx (tap_idx_ff),
      .cfg     (cfg)
   );

   // Subtraction in the address width wraps modulo the memory depth
   wire logic [AW-1:0] raddr = wptr_ff - cfg.delay;   // [RL13]

   // Memory has no reset; a fresh power-up plays stale words until filled
   always_ff @(posedge clk_sys) begin
      if (state_ff == ST_WRITE) begin
         mem[wptr_ff] <= in_word;   // [RL1] [RL2]
      end
      rdata_ff <= mem[raddr];
   end

   // Gain and channel travel alongside the read word
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_valid_ff <= 1'b0;
         rd_right_ff <= 1'b0;
         rd_gain_ff  <= '0;
      end else begin
         rd_valid_ff <= (state_ff == ST_TAP);
         rd_right_ff <= (tap_idx_ff >= delay_pkg::TAP_SPLIT);   // [RL3]
         rd_gain_ff  <= cfg.gain;                               // [RL4]
      end
   end

   // ***************************************************************
   // Channel sums and outputs
   // ***************************************************************

   tap_mac u_left (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .clear   (state_ff == ST_WRITE),
      .add_en  (rd_valid_ff && !rd_right_ff),
      .word    (rdata_ff),
      .gain    (rd_gain_ff),
      .result  (left_sum)
   );

   tap_mac u_right (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .clear   (state_ff == ST_WRITE),
      .add_en  (rd_valid_ff && rd_right_ff),
      .word    (rdata_ff),
      .gain    (rd_gain_ff),
      .result  (right_sum)
   );

   // Bypass takes the captured inputs, mono feeds left to both sides
   wire logic signed [15:0] byp_right = ctrl_ff.mono ? in_l_ff : in_r_ff;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         left_out_ff  <= '0;
         right_out_ff <= '0;
         out_valid_ff <= 1'b0;
      end else begin
         out_valid_ff <= (state_ff == ST_OUT);
         if (state_ff == ST_OUT) begin
            left_out_ff  <= bypass_ff ? in_l_ff : left_sum;     // [RL11]
            right_out_ff <= bypass_ff ? byp_right : right_sum;  // [RL11]
         end
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign left_out  = left_out_ff;
   assign right_out = right_out_ff;
   assign out_valid = out_valid_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_tap_run;
      (state_ff == ST_WRITE) ##1 (state_ff == ST_TAP) [*8];
   endsequence

   a_write_word_sel: assert property ((state_ff == ST_WRITE) |-> ##1   // [RL1]
      (mem[$past(wptr_ff)] == (ctrl_ff.mono ? {in_l_ff, 1'b0} : WW'(in_l_ff) + WW'(in_r_ff))))
      else $error("memory word does not match input setting");

   a_ptr_advance: assert property ((state_ff == ST_OUT) |=>   // [RL13]
      (wptr_ff == $past(wptr_ff) + 14'h0001) && (state_ff == ST_IDLE))
      else $error("write pointer did not step once per sample");

   a_twelve_taps: assert property (s_tap_run |-> ##5 (state_ff == ST_LAST) ##1   // [RL3]
      (state_ff == ST_OUT) ##1 out_valid_ff)
      else $error("tap sequence is not twelve reads long");

   a_read_addr_wrap: assert property ((state_ff == ST_TAP) |->   // [RL13]
      (14'(raddr + cfg.delay) == wptr_ff))
      else $error("tap address not pointer minus delay");

   a_bypass_route: assert property ((state_ff == ST_OUT) && bypass_ff |=>   // [RL11]
      (left_out_ff == $past(in_l_ff)) && (right_out_ff == $past(byp_right)))
      else $error("bypass does not route inputs to outputs");

   a_bypass_or: assert property (($fell(remote_s2_ff) || $rose(ctrl_ff.bypass_btn)) |=>   // [RL12]
      bypass_ff)
      else $error("one bypass source did not enable bypass");

   a_dry_tap_zero: assert property ((state_ff == ST_TAP) && (tap_idx_ff == 4'h0) &&   // [RL8]
      ((ctrl_ff.mode == delay_pkg::MODE_ROOM) || (ctrl_ff.mode == delay_pkg::MODE_CLUSTER))
      |-> (cfg.delay == '0) ##1 (rd_gain_ff == 8'(delay_pkg::GAIN_UNITY
      - 8'(ctrl_ff.p2) * delay_pkg::GAIN_MIX_STEP)))
      else $error("dry tap not at zero delay with mix gain");

   a_repeat_taps_off: assert property ((state_ff == ST_TAP) &&   // [RL9]
      (ctrl_ff.mode == delay_pkg::MODE_REPEAT) && (tap_idx_ff == 4'h5) &&
      (ctrl_ff.p2 < 4'h8) |=> (rd_gain_ff == 8'h00) && rd_valid_ff)
      else $error("repeat tap not switched off by selector");

   a_apb_answer: assert property (apb_start |=> pready_ff ##1 !pready_ff)
      else $error("APB answer not a single ready cycle");

endmodule

// file: tap_mac.sv
// Multiply-accumulate for one output channel with output saturation
`timescale 1ns/1ps
module tap_mac #(
   parameter int unsigned WORD_W = delay_pkg::WORD_W,
   parameter int unsigned GAIN_W = delay_pkg::GAIN_W,
   parameter int unsigned ACC_W  = delay_pkg::ACC_W,
   parameter int unsigned OUT_W  = delay_pkg::IN_W,
   parameter int unsigned SHIFT  = delay_pkg::OUT_SHIFT
) (
   input  wire logic                     clk_sys,  // System clock
   input  wire logic                     resetn,   // Async reset, low
   input  wire logic                     clear,    // Start a new sum
   input  wire logic                     add_en,   // Add one tap
   input  wire logic signed [WORD_W-1:0] word,     // Delayed sample
   input  wire logic signed [GAIN_W-1:0] gain,     // Signed tap gain
   output wire logic signed [OUT_W-1:0]  result    // Saturated sum
);

   logic signed [ACC_W-1:0]         acc_ff;
   logic signed [ACC_W-1:0]         nxt_acc;
   wire logic signed [WORD_W+GAIN_W-1:0] product = word * gain;
   wire logic signed [ACC_W-1:0]    shifted = acc_ff >>> SHIFT;
   wire logic                       ovf;

   // Sign and gain are applied before the sum
   assign nxt_acc = clear  ? '0 :
                    add_en ? acc_ff + ACC_W'(product) : acc_ff;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   // Clip rather than wrap: a wrap would turn a loud peak into a full-scale click
   assign ovf    = (shifted[ACC_W-1:OUT_W-1] != {(ACC_W-OUT_W+1){shifted[ACC_W-1]}});
   assign result = ovf ? {shifted[ACC_W-1], {(OUT_W-1){~shifted[ACC_W-1]}}}
                       : shifted[OUT_W-1:0];

endmodule

// file: tap_preset.sv
// Preset tables: tap delay, sign and gain from mode and the two selectors
`timescale 1ns/1ps
module tap_preset (
   input  delay_pkg::ctrl_s    ctrl,     // Mode and selectors
   input  wire logic [3:0]     tap_idx,  // Tap 0..11
   output delay_pkg::tap_cfg_s cfg       // Delay and gain for the tap
);

   wire logic        right   = (tap_idx >= delay_pkg::TAP_SPLIT);
   wire logic [2:0]  pos     = 3'(right ? tap_idx - delay_pkg::TAP_SPLIT : tap_idx) + 3'h1;
   wire logic        first   = (pos == 3'h1);
   wire logic        is_dry  = (ctrl.mode == delay_pkg::MODE_ROOM) ||
                               (ctrl.mode == delay_pkg::MODE_CLUSTER);
   wire logic        is_rep  = (ctrl.mode == delay_pkg::MODE_REPEAT);
   // Delay placement: mode picks the table, p1 the spacing; p2 never enters
   wire logic [11:0] step    = 12'(delay_pkg::DELAY_STEP[ctrl.mode]) * (12'(ctrl.p1) + 12'h001);
   // A unit step has no half step, so its right taps move past the six left ones
   wire logic        unit    = (step == 12'h001);
   wire logic [16:0] full    = 17'(step) * 17'(pos) - (right ? 17'(step >> 1) : 17'h00000)
                               + ((right && unit) ? 17'(delay_pkg::TAP_SPLIT) : 17'h00000);
   // Gain: p2 picks amplitude, mode and tap place set polarity; p1 never enters
   wire logic        rep_on  = ({1'b0, pos} <= (4'(ctrl.p2 >> 1) + 4'h1));
   wire logic [7:0]  mag;
   wire logic        neg     = (ctrl.mode == delay_pkg::MODE_COMB) && right && !first;

   // Right taps sit half a step off the left ones so only the two dry taps of room and cluster read the same word
   assign cfg.delay = (is_dry && first)        ? '0 :                  // [RL8]
                      (full > delay_pkg::DELAY_MAX) ? delay_pkg::DELAY_MAX[13:0]
                                                    : full[13:0];      // [RL6] [RL10]
   assign mag = is_rep ? (rep_on ? delay_pkg::GAIN_TAP : 8'h00) :        // [RL9]
                first  ? delay_pkg::GAIN_UNITY - 8'(ctrl.p2) * delay_pkg::GAIN_MIX_STEP :
                         8'(ctrl.p2);                                   // [RL7] [RL8]
   assign cfg.gain = neg ? -$signed(mag) : $signed(mag);               // [RL4] [RL5]

endmodule

// file: test_multi_tap_stereo_delay.sv
// Self-checking bench for the stereo tap delay engine
`timescale 1ns/1ps
module test_multi_tap_stereo_delay;
   logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, out_valid, remote_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] left_in, right_in, left_out, right_out, nl, nr;
   int          err_total, num_checks;
   wire         bypass_remote_n;
   // ***************************************************************
   // Engine and converter model
   // ***************************************************************
   stereo_tap_delay u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .left_in(left_in), .right_in(right_in),
      .bypass_remote_n(bypass_remote_n), .left_out(left_out), .right_out(right_out),
      .out_valid(out_valid));
   audio_conv_model u_conv (.clk_sys(clk_sys), .resetn(resetn), .out_valid(out_valid),
      .next_l(nl), .next_r(nr), .remote_on(remote_on), .left_in(left_in),
      .right_in(right_in), .bypass_remote_n(bypass_remote_n));
   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Hangs are cut short by the watchdog, not by a local count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic samples(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         while (out_valid !== 1'b1) @(posedge clk_sys);
      end
   endtask
   function automatic logic [31:0] cw(logic mo, logic by, logic [2:0] md, logic [3:0] a,
                                      logic [3:0] b);
      delay_pkg::ctrl_s c;
      c = '{p2: b, p1: a, mode: delay_pkg::mode_e'(md), bypass_btn: by, mono: mo};
      return {19'h00000, c};
   endfunction
   // Fourteen samples refill every tap used below after a control change
   task automatic setc(input logic [31:0] c, input int n);
      logic e;
      apb(1'b1, 12'h000, c, e);
      samples(n);
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_regs();
      logic e;
      apb(1'b0, 12'h000, 32'h0, e);
      chk(rd, 32'h00000000);
      apb(1'b1, 12'h000, 32'hFFFFFFFF, e);
      apb(1'b0, 12'h000, 32'h0, e);
      chk(rd, 32'h00001FFF);
      apb(1'b0, 12'h008, 32'h0, e);
      chk({31'h0, e}, 32'h00000001);
      apb(1'b1, 12'h004, 32'h0, e);
      chk({31'h0, e}, 32'h00000001);
      $display("register access done");
   endtask
   // Constant input: L+R = 0x180; unity gain halves it, p2=1 gives 65 and 55 sixty-fourths
   task automatic t_comb();
      nl <= 16'h0100;
      nr <= 16'h0080;
      setc(cw(0, 0, 3'h1, 4'h0, 4'h0), 14);
      chk(left_out, 32'h000000C0);
      chk(right_out, 32'h000000C0);
      setc(cw(0, 0, 3'h1, 4'h0, 4'h1), 14);
      chk(left_out, 32'h000000C3);
      chk(right_out, 32'h000000A5);
      setc(cw(0, 0, 3'h1, 4'h1, 4'h1), 14);
      chk(left_out, 32'h000000C3);
      chk(right_out, 32'h000000A5);
      setc(cw(0, 0, 3'h0, 4'h0, 4'h1), 14);
      chk(right_out, 32'h000000C3);
      setc(cw(1, 0, 3'h1, 4'h0, 4'h0), 14);
      chk(left_out, 32'h00000100);
      $display("tap sums done");
   endtask
   task automatic t_byp();
      logic e;
      nl <= 16'h1234;
      nr <= 16'hFA99;
      setc(cw(0, 1, 3'h2, 4'h5, 4'h9), 3);
      chk(left_out, 32'h00001234);
      chk(right_out, 32'h0000FA99);
      setc(cw(1, 1, 3'h2, 4'h5, 4'h9), 3);
      chk(right_out, 32'h00001234);
      remote_on <= 1'b1;
      setc(cw(0, 0, 3'h2, 4'h5, 4'h9), 3);
      apb(1'b0, 12'h004, 32'h0, e);
      chk({31'h0, rd[16]}, 32'h00000001);
      chk(right_out, 32'h0000FA99);
      remote_on <= 1'b0;
      setc(cw(0, 0, 3'h2, 4'h5, 4'h9), 3);
      apb(1'b0, 12'h004, 32'h0, e);
      chk({31'h0, rd[16]}, 32'h00000000);
      $display("bypass done");
   endtask
   task automatic t_wptr();
      logic        e;
      logic [13:0] p;
      samples(1);
      apb(1'b0, 12'h004, 32'h0, e);
      p = rd[13:0] + 14'h0001;
      samples(1);
      apb(1'b0, 12'h004, 32'h0, e);
      chk({18'h0, rd[13:0]}, {18'h0, p});
      $display("write pointer done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ***************************************************************
   // Clock, reset, sequence and watchdog
   // ***************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {psel, penable, pwrite, remote_on, paddr, pwdata, nl, nr} = '0;
      resetn = 1'b0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_comb();
      t_byp();
      t_wptr();
      results();
   end
   // About 40k cycles are expected; twice that means a hang
   initial begin
      #4_000_000;
      err_total++;
      results();
   end
endmodule
